// ===== core/spos_defines.vh
`ifndef SPOS_DEFINES_VH
`define SPOS_DEFINES_VH

// ----------------------------------------------------------------------------
// Function codes.
// ----------------------------------------------------------------------------
`define SPOS_CODE_LOW        8'h80
`define SPOS_CODE_HIGH       8'h81
`define SPOS_CODE_CLKDIV     8'h82
`define SPOS_CODE_WDOG       8'h83
`define SPOS_CODE_SYN_CAL    8'h84
`define SPOS_CODE_SYN_LOCK   8'h85
`define SPOS_CODE_SYN_STABLE 8'h86
`define SPOS_CODE_ALL_LOCK   8'h87
`define SPOS_CODE_CH_LOCK    8'h88
`define SPOS_CODE_NVM_WR     8'h8C
`define SPOS_CODE_NVM_RD     8'h8D
`define SPOS_CODE_NVM_FAULT  8'h8E
`define SPOS_CODE_IRQ_ALL    8'h90
`define SPOS_CODE_IRQ_COMMON 8'h91
`define SPOS_CODE_IRQ_CH     8'h92
`define SPOS_CODE_REF_FAULT  8'hA0
`define SPOS_CODE_REF_VALID  8'hA8
`define SPOS_CODE_REF_ACTIVE 8'hB0

// ----------------------------------------------------------------------------
// Field positions and timing.
// ----------------------------------------------------------------------------
`define SPOS_SEL_MSB         7
`define SPOS_SYN_LOCK_BIT    0
`define SPOS_SYN_STABLE_BIT  1
`define SPOS_SYN_CAL_BIT     2
`define SPOS_REF_FAULT_BIT   2
`define SPOS_REF_VALID_BIT   3
`define SPOS_REF_ACT_LSB     4
`define SPOS_REF_ACT_MSB     7
`define SPOS_CLKDIV_RATIO    32
`define SPOS_HALF_DIV        4'hF
`define SPOS_STROBE_CYCLES   6'h20
`define SPOS_PIN_RESET       1'b0
`define SPOS_DIV_RESET       4'h0
`define SPOS_DIV_CLK_RESET   1'b0
`define SPOS_STROBE_IDLE     6'h00
`define SPOS_CH_LOCK_RESET   4'h0
`define SPOS_NVM_WR_BIT      0
`define SPOS_NVM_RD_BIT      1
`define SPOS_NVM_FAULT_BIT   2

`endif

// ===== core/spos_selector.v
`timescale 1ns/10ps
`default_nettype none
`include "spos_defines.vh"

module spos_selector (
  input  wire       i_clk,              // Core timebase.
  input  wire       i_resetn,           // Asynchronous reset, active low.
  input  wire       i_ce,               // Clock enable; state freezes while low.
  input  wire [7:0] i_func_code,        // Pin function code.
  input  wire       i_wdog_expire,      // One-cycle watchdog expiry pulse.
  input  wire [7:0] i_common_status,    // Common status byte (synthesizer bits).
  input  wire [3:0] i_digital_lock,     // Digital loop phase lock, ch3..ch0.
  input  wire [3:0] i_analog_lock,      // Analog loop lock, ch3..ch0.
  input  wire [2:0] i_nvm_status,       // Nonvolatile fault, read, write.
  input  wire       i_irq_common,       // Shared interrupt line.
  input  wire [3:0] i_irq_ch,           // Per-channel interrupt lines.
  input  wire [7:0] i_ref_status_a,     // Reference input A status byte.
  input  wire [7:0] i_ref_status_b,     // Reference input B status byte.
  input  wire [7:0] i_ref_status_c,     // Reference input C status byte.
  input  wire [7:0] i_ref_status_d,     // Reference input D status byte.
  output reg        o_pin,              // Multifunction pin level.
  output reg  [3:0] o_ch_lock           // Combined per-channel lock flags.
);

  // --------------------------------------------------------------------------
  // Derived flags.
  // --------------------------------------------------------------------------
  wire        syn_lock = i_common_status[`SPOS_SYN_LOCK_BIT];
  wire [3:0]  ch_lock;
  wire [3:0]  ref_fault;
  wire [3:0]  ref_valid;
  wire [3:0]  ref_active;
  wire [31:0] ref_bus = {i_ref_status_d, i_ref_status_c, i_ref_status_b, i_ref_status_a};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      assign ch_lock[g]    = i_digital_lock[g] & i_analog_lock[g] & syn_lock;
      assign ref_fault[g]  = ref_bus[8*g + `SPOS_REF_FAULT_BIT];
      assign ref_valid[g]  = ref_bus[8*g + `SPOS_REF_VALID_BIT];
      assign ref_active[g] = |ref_bus[8*g + `SPOS_REF_ACT_MSB : 8*g + `SPOS_REF_ACT_LSB];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Divider and watchdog strobe.
  // --------------------------------------------------------------------------
  // The divided clock toggles every sixteen cycles, giving a period of 32.
  reg [3:0] div_cnt_q;
  reg       div_clk_q;
  reg [5:0] strobe_cnt_q;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_q    <= `SPOS_DIV_RESET;
      div_clk_q    <= `SPOS_DIV_CLK_RESET;
      strobe_cnt_q <= `SPOS_STROBE_IDLE;
    end else if (i_ce) begin
      div_cnt_q <= div_cnt_q + 4'h1;
      if (div_cnt_q == `SPOS_HALF_DIV) begin
        div_clk_q <= ~div_clk_q;
      end
      // An expiry during a running strobe is absorbed rather than stretching it.
      if (i_wdog_expire && (strobe_cnt_q == 6'h00)) begin
        strobe_cnt_q <= `SPOS_STROBE_CYCLES;
      end else if (strobe_cnt_q != 6'h00) begin
        strobe_cnt_q <= strobe_cnt_q - 6'h01;
      end
    end
  end

  wire strobe_on = (strobe_cnt_q != 6'h00);

  // --------------------------------------------------------------------------
  // Function selection.
  // --------------------------------------------------------------------------
  // Each listed code has its own item, so a code outside the table with bit 7 set can only
  // reach the default branch and hold the pin low.
  reg pin_d;

  always @* begin
    pin_d = 1'b0;
    if (i_func_code[`SPOS_SEL_MSB]) begin
      case (i_func_code)
        `SPOS_CODE_LOW: begin
          pin_d = 1'b0;
        end
        `SPOS_CODE_HIGH: begin
          pin_d = 1'b1;
        end
        `SPOS_CODE_CLKDIV: begin
          pin_d = div_clk_q;
        end
        `SPOS_CODE_WDOG: begin
          pin_d = strobe_on;
        end
        `SPOS_CODE_SYN_CAL: begin
          pin_d = i_common_status[`SPOS_SYN_CAL_BIT];
        end
        `SPOS_CODE_SYN_LOCK: begin
          pin_d = syn_lock;
        end
        `SPOS_CODE_SYN_STABLE: begin
          pin_d = i_common_status[`SPOS_SYN_STABLE_BIT];
        end
        `SPOS_CODE_ALL_LOCK: begin
          pin_d = &ch_lock;
        end
        `SPOS_CODE_CH_LOCK: begin
          pin_d = ch_lock[0];
        end
        (`SPOS_CODE_CH_LOCK + 8'h01): begin
          pin_d = ch_lock[1];
        end
        (`SPOS_CODE_CH_LOCK + 8'h02): begin
          pin_d = ch_lock[2];
        end
        (`SPOS_CODE_CH_LOCK + 8'h03): begin
          pin_d = ch_lock[3];
        end
        `SPOS_CODE_NVM_WR: begin
          pin_d = i_nvm_status[`SPOS_NVM_WR_BIT];
        end
        `SPOS_CODE_NVM_RD: begin
          pin_d = i_nvm_status[`SPOS_NVM_RD_BIT];
        end
        `SPOS_CODE_NVM_FAULT: begin
          pin_d = i_nvm_status[`SPOS_NVM_FAULT_BIT];
        end
        `SPOS_CODE_IRQ_ALL: begin
          pin_d = i_irq_common | (|i_irq_ch);
        end
        `SPOS_CODE_IRQ_COMMON: begin
          pin_d = i_irq_common;
        end
        `SPOS_CODE_IRQ_CH: begin
          pin_d = i_irq_ch[0];
        end
        (`SPOS_CODE_IRQ_CH + 8'h01): begin
          pin_d = i_irq_ch[1];
        end
        (`SPOS_CODE_IRQ_CH + 8'h02): begin
          pin_d = i_irq_ch[2];
        end
        (`SPOS_CODE_IRQ_CH + 8'h03): begin
          pin_d = i_irq_ch[3];
        end
        `SPOS_CODE_REF_FAULT: begin
          pin_d = ref_fault[0];
        end
        (`SPOS_CODE_REF_FAULT + 8'h01): begin
          pin_d = ref_fault[1];
        end
        (`SPOS_CODE_REF_FAULT + 8'h02): begin
          pin_d = ref_fault[2];
        end
        (`SPOS_CODE_REF_FAULT + 8'h03): begin
          pin_d = ref_fault[3];
        end
        `SPOS_CODE_REF_VALID: begin
          pin_d = ref_valid[0];
        end
        (`SPOS_CODE_REF_VALID + 8'h01): begin
          pin_d = ref_valid[1];
        end
        (`SPOS_CODE_REF_VALID + 8'h02): begin
          pin_d = ref_valid[2];
        end
        (`SPOS_CODE_REF_VALID + 8'h03): begin
          pin_d = ref_valid[3];
        end
        `SPOS_CODE_REF_ACTIVE: begin
          pin_d = ref_active[0];
        end
        (`SPOS_CODE_REF_ACTIVE + 8'h01): begin
          pin_d = ref_active[1];
        end
        (`SPOS_CODE_REF_ACTIVE + 8'h02): begin
          pin_d = ref_active[2];
        end
        (`SPOS_CODE_REF_ACTIVE + 8'h03): begin
          pin_d = ref_active[3];
        end
        default: begin
          pin_d = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Output register.
  // --------------------------------------------------------------------------
  // Registering the selected level keeps decode hazards of a code or source
  // change off the pin, at the cost of one cycle of latency.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin     <= `SPOS_PIN_RESET;
      o_ch_lock <= `SPOS_CH_LOCK_RESET;
    end else if (i_ce) begin
      o_pin     <= pin_d;
      o_ch_lock <= ch_lock;
    end
  end

endmodule // spos_selector

`default_nettype wire

// ===== dv/spos_pin_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module spos_pin_monitor (
  input  wire logic       i_clk,      // Core timebase.
  input  wire logic       i_pin,      // Watched pin.
  output var  logic [7:0] o_high_run, // Last whole high run, in cycles.
  output var  logic [7:0] o_rises     // Rising edges seen.
);
  logic [7:0] run_q  = 8'h00;
  logic       last_q = 1'b0;
  initial {o_high_run, o_rises} = 16'h0000;
  always @(posedge i_clk) begin
    last_q <= i_pin;
    run_q  <= i_pin ? run_q + 8'h01 : 8'h00;
    if (last_q && !i_pin) o_high_run <= run_q;
    if (!last_q && i_pin) o_rises <= o_rises + 8'h01;
  end
endmodule // spos_pin_monitor
`default_nettype wire

// ===== dv/spos_selector_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module spos_selector_asserts (
  input wire logic       i_clk,           // Core timebase.
  input wire logic       i_resetn,        // Reset, active low.
  input wire logic       i_ce,            // Clock enable.
  input wire logic       i_wdog_expire,   // Watchdog expiry pulse.
  input wire logic       o_pin,           // Watched pin.
  input wire logic [7:0] i_func_code,     // Pin function code.
  input wire logic [7:0] i_common_status, // Synthesizer status bits.
  input wire logic [7:0] i_ref_status_a,  // Reference input A status.
  input wire logic [3:0] i_digital_lock,  // Digital loop locks.
  input wire logic [3:0] i_analog_lock,   // Analog loop locks.
  input wire logic [3:0] o_ch_lock        // Combined channel locks.
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_ready;
    i_ce && i_func_code == 8'h83;
  endsequence
  sequence s_arm;
    i_ce && i_wdog_expire && !o_pin && i_func_code == 8'h83;
  endsequence
  sequence s_hold;
    (i_ce && i_func_code == 8'h83) [*3];
  endsequence
  low_code_a: assert property (i_ce && i_func_code == 8'h80 |=> !o_pin)
    else $error("Pin not low.");
  high_code_a: assert property (i_ce && i_func_code == 8'h81 |=> o_pin)
    else $error("Pin not high.");
  msb_clear_a: assert property (i_ce && !i_func_code[7] |=> !o_pin)
    else $error("Pin driven with select clear.");
  syn_lock_a: assert property (i_ce && i_func_code == 8'h85 |=> o_pin == $past(i_common_status[0]))
    else $error("Lock mirror wrong.");
  ch_lock_a: assert property (i_ce |=> o_ch_lock == $past(i_digital_lock & i_analog_lock & {4{i_common_status[0]}}))
    else $error("Channel locks wrong.");
  all_lock_a: assert property (i_ce && i_func_code == 8'h87 |=> o_pin == $past(&(i_digital_lock & i_analog_lock) && i_common_status[0]))
    else $error("All-lock wrong.");
  ref_fault_a: assert property (i_ce && i_func_code == 8'hA0 |=> o_pin == $past(i_ref_status_a[2]))
    else $error("Fault mirror wrong.");
  strobe_start_a: assert property (s_ready ##1 s_arm ##1 s_hold |-> o_pin)
    else $error("Strobe missing.");
  ce_freeze_a: assert property (!i_ce |=> $stable(o_pin) && $stable(o_ch_lock))
    else $error("Outputs moved with clock enable low.");
endmodule // spos_selector_asserts
bind spos_selector spos_selector_asserts chk (.i_clk, .i_resetn, .i_ce, .i_wdog_expire, .o_pin,
  .i_func_code, .i_common_status, .i_ref_status_a, .i_digital_lock, .i_analog_lock, .o_ch_lock);
`default_nettype wire

// ===== dv/spos_selector_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spos_selector_tb;
  logic       i_clk, i_resetn, i_ce, i_wdog_expire, i_irq_common;
  logic [7:0] i_func_code, i_common_status, i_ref_status_a, i_ref_status_b, i_ref_status_c;
  logic [7:0] i_ref_status_d, r0;
  logic [3:0] i_digital_lock, i_analog_lock, i_irq_ch;
  logic [2:0] i_nvm_status;
  wire        o_pin;
  wire  [3:0] o_ch_lock;
  wire  [7:0] hr, rs;
  int failures = 0, cmp_count = 0, cyc = 0;
  // Bit 8 is the expected pin level, bits 7:0 the code.
  logic [8:0] t1 [28] = '{9'h080, 9'h181, 9'h184, 9'h185, 9'h086, 9'h087, 9'h188, 9'h189, 9'h08A,
    9'h18B, 9'h18C, 9'h08D, 9'h18E, 9'h08F, 9'h190, 9'h091, 9'h092, 9'h194, 9'h1A0, 9'h0A1,
    9'h0A3, 9'h0A8, 9'h1A9, 9'h0B0, 9'h0B2, 9'h1B3, 9'h001, 9'h0AC};
  logic [8:0] t2 [20] = '{9'h086, 9'h185, 9'h187, 9'h18B, 9'h084, 9'h190, 9'h191, 9'h092, 9'h08C,
    9'h18D, 9'h08E, 9'h1B0, 9'h0B1, 9'h1B2, 9'h0B3, 9'h1A3, 9'h1AB, 9'h0A0, 9'h1A1, 9'h0A8};
  logic [8:0] t3 [9] = '{9'h085, 9'h186, 9'h087, 9'h088, 9'h08B, 9'h195, 9'h190, 9'h091, 9'h094};
  spos_selector uut (.i_clk, .i_resetn, .i_ce, .i_func_code, .i_wdog_expire, .i_common_status,
    .i_digital_lock, .i_analog_lock, .i_nvm_status, .i_irq_common, .i_irq_ch, .i_ref_status_a,
    .i_ref_status_b, .i_ref_status_c, .i_ref_status_d, .o_pin, .o_ch_lock);
  spos_pin_monitor mon (.i_clk, .i_pin(o_pin), .o_high_run(hr), .o_rises(rs));
  task check(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task setup(input logic [23:0] v, input logic [31:0] r);
    @(posedge i_clk);
    {i_common_status, i_digital_lock, i_analog_lock, i_irq_ch, i_nvm_status, i_irq_common} <= v;
    {i_ref_status_a, i_ref_status_b, i_ref_status_c, i_ref_status_d} <= r;
  endtask
  task probe(input logic [8:0] e);
    @(posedge i_clk) i_func_code <= e[7:0];
    @(posedge i_clk);
    #1 check("pin", {7'h00, o_pin}, {7'h00, e[8]});
  endtask
  task pulse;
    i_wdog_expire <= 1'b1;
    @(posedge i_clk) i_wdog_expire <= 1'b0;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {i_resetn, i_ce, i_wdog_expire, i_irq_common, i_func_code, r0} = 20'h40000;
    {i_common_status, i_digital_lock, i_analog_lock, i_irq_ch, i_nvm_status} = '0;
    {i_ref_status_a, i_ref_status_b, i_ref_status_c, i_ref_status_d} = '0;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    setup(24'h05BF4A, 32'h04080080);
    foreach (t1[k]) probe(t1[k]);
    check("ch_lock", {4'h0, o_ch_lock}, 8'h0B);
    @(posedge i_clk) i_func_code <= 8'h81;
    @(posedge i_clk);
    @(posedge i_clk) i_resetn <= 1'b0;
    #1 check("rst_pin", {7'h00, o_pin}, 8'h00);
    check("rst_lock", {4'h0, o_ch_lock}, 8'h00);
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    #1 check("rst_exit", {7'h00, o_pin}, 8'h01);
    setup(24'h01FF05, 32'h1004400C);
    foreach (t2[k]) probe(t2[k]);
    setup(24'h02FF80, 32'h00000000);
    foreach (t3[k]) probe(t3[k]);
    @(posedge i_clk) i_ce <= 1'b0;
    i_func_code <= 8'h81;
    repeat (3) @(posedge i_clk);
    #1 check("ce_hold", {7'h00, o_pin}, 8'h00);
    @(posedge i_clk) i_ce <= 1'b1;
    @(posedge i_clk);
    #1 check("ce_run", {7'h00, o_pin}, 8'h01);
    @(posedge i_clk) i_func_code <= 8'h82;
    repeat (80) @(posedge i_clk);
    #1 check("div_high", hr, 8'h10);
    @(posedge i_clk) i_func_code <= 8'h83;
    repeat (3) @(posedge i_clk);
    r0 = rs;
    pulse();
    // A second expiry inside the strobe must neither stretch nor restart it.
    repeat (5) @(posedge i_clk);
    pulse();
    repeat (60) @(posedge i_clk);
    check("strobe_len", hr, 8'h20);
    check("strobe_cnt", rs - r0, 8'h01);
    summarize();
  end
endmodule // spos_selector_tb
`default_nettype wire
